/* File: design/dual_board_powerup_stagger.sv */
// Purpose: Staggers 12.5V enables to two board slots after power arrives.
// Assumes: Pins are asynchronous and pass two flip-flops before use.
// Notes: The stagger delay is a plain input, clamped into its legal range.
// Contract
// [RULE1] Never enable both slots at the same moment.
// [RULE2] Delay is settable from one second to one minute, thirty by default.
// [RULE3] Both boards at power arrival: slot 0 first, slot 1 after delay.
// [RULE4] Re-seated board while both run is re-enabled without delay.
// [RULE5] Only slot 0 occupied at power arrival: enable it at once.
// [RULE6] Only slot 1 occupied at power arrival: enable it at once.
// [RULE7] Newcomer into empty slot beside running board powers without delay.
// [RULE8] Both empty at power arrival, later inserted: still apply delay.
// [RULE9] Boards drive seated low when mated; high means empty slot.
// [RULE10] Boards drive a power request when starting power-on.
// [RULE11] Supply power-good is active high; power exists only while high.
// [RULE12] Fans of an unpowered slot are switched off.
// [RULE13] Timer counts whole seconds from slot 0 enable, no restart.
// [RULE14] Loss of power-good returns to start with both slots off.
`timescale 1ns/1ps
module dual_board_powerup_stagger
  import stagger_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CYCLES_PER_SEC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Supply and slot pins.
  input wire logic supply_power_good,
  input wire logic [SLOTS-1:0] board_seated_n,
  input wire logic [SLOTS-1:0] board_power_request,
  // Stagger setting in seconds.
  input wire logic [SEC_W-1:0] delay_sec,
  // Slot power and fan enables.
  output logic [SLOTS-1:0] slot_power_en,
  output logic [SLOTS-1:0] slot_fan_en,
  // Sequencer observation.
  output logic [SLOTS-1:0] board_running
);

  // Refuse a prescaler too short to form a one-second tick.
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least two");
  end

  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic pg_s1_ff, pg_ff;
  logic [SLOTS-1:0] seat_s1_ff, seat_ff, req_s1_ff, req_ff;
  logic [SLOTS-1:0] present;
  logic [SLOTS-1:0] en_ff;
  seq_state_t state_ff;
  logic both_at_start_ff;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic sec_tick;
  logic [SEC_W-1:0] sec_ff;
  logic [SEC_W-1:0] delay_eff;
  logic delay_done;

  // Two-stage synchronisers for the power-good, seated and request pins.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pg_s1_ff <= 1'b0;
      pg_ff <= 1'b0;
      seat_s1_ff <= '1;
      seat_ff <= '1;
      req_s1_ff <= '0;
      req_ff <= '0;
    end else begin
      pg_s1_ff <= supply_power_good;
      pg_ff <= pg_s1_ff; // see [RULE11]
      seat_s1_ff <= board_seated_n;
      seat_ff <= seat_s1_ff;
      req_s1_ff <= board_power_request;
      req_ff <= req_s1_ff;
    end
  end

  // A low seated level marks an occupied slot.
  assign present = ~seat_ff; // see [RULE9]

  // The delay setting is clamped to the legal range.
  always_comb begin
    if (delay_sec < DELAY_MIN) begin
      delay_eff = DELAY_MIN;
    end else if (delay_sec > DELAY_MAX) begin
      delay_eff = DELAY_MAX;
    end else begin
      delay_eff = delay_sec; // see [RULE2]
    end
  end

  // Sequencer: decides stagger once per power application.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      both_at_start_ff <= 1'b0;
    end else if (!pg_ff) begin
      state_ff <= ST_IDLE; // see [RULE14]
      both_at_start_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_EVAL;
        end
        ST_EVAL: begin
          // Both present, or both empty, means slot 1 waits its turn.
          if (present == 2'b11 || present == 2'b00) begin
            both_at_start_ff <= 1'b1; // see [RULE3] see [RULE8]
            state_ff <= ST_WAIT;
          end else begin
            both_at_start_ff <= 1'b0; // see [RULE5] see [RULE6]
            state_ff <= ST_RUN;
          end
        end
        ST_WAIT: begin
          if (en_ff[0] && delay_done) begin
            state_ff <= ST_RUN;
          end else if (en_ff[1] && !en_ff[0]) begin
            // Slot 1 came up alone while slot 0 was empty.
            state_ff <= ST_RUN; // see [RULE7]
          end
        end
        ST_RUN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Seconds prescaler, running while slot 0 is enabled and waiting.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tick_cnt_ff <= '0;
    end else if (!(state_ff == ST_WAIT && en_ff[0])) begin
      tick_cnt_ff <= '0;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end
  assign sec_tick = (state_ff == ST_WAIT) && en_ff[0] &&
                    (tick_cnt_ff == TICK_LAST);

  // Whole-second counter; starts with slot 0 and never restarts meanwhile.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sec_ff <= '0;
    end else if (!(state_ff == ST_WAIT && en_ff[0])) begin
      sec_ff <= '0;
    end else if (sec_tick && !delay_done) begin
      sec_ff <= sec_ff + 1'b1; // see [RULE13]
    end
  end
  assign delay_done = (sec_ff >= delay_eff);

  // Slot enables.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      en_ff <= '0;
    end else if (!pg_ff || state_ff == ST_IDLE || state_ff == ST_EVAL) begin
      en_ff <= '0; // see [RULE14]
    end else begin
      // Slot 0 follows its seat in every running state.
      en_ff[0] <= present[0];
      if (state_ff == ST_RUN) begin
        // Immediate (re-)enable once staggering is settled, but a slot 1
        // that would rise together with slot 0 lags it by one cycle.
        en_ff[1] <= present[1] && // see [RULE7]
                    (en_ff[0] || !present[0]); // see [RULE1] see [RULE4]
      end else if (!en_ff[0] && !present[0]) begin
        // Slot 0 empty: slot 1 alone may start without wait, but only while both_at_start_ff is clear.
        en_ff[1] <= present[1] && !both_at_start_ff;
      end else begin
        en_ff[1] <= 1'b0; // see [RULE1] see [RULE3]
      end
    end
  end

  assign slot_power_en = en_ff;
  // Fans are off for any slot whose board is unpowered.
  assign slot_fan_en = en_ff; // see [RULE12]
  // A board counts as running when powered and requesting power-on.
  assign board_running = en_ff & req_ff;

  // Slot 1 never turns on together with slot 0.
  property p_no_joint_start;
    @(posedge clock) disable iff (reset)
    !($rose(en_ff[0]) && $rose(en_ff[1]));
  endproperty
  a_no_joint_start: assert property (p_no_joint_start) // see [RULE1]
    else $error("Both slots enabled in the same cycle");

  // Slot 1 waits in the stagger state while the delay is unfinished.
  property p_stagger_hold;
    @(posedge clock) disable iff (reset)
    (state_ff == ST_WAIT && en_ff[0] && !delay_done) |=> !en_ff[1];
  endproperty
  a_stagger_hold: assert property (p_stagger_hold) // see [RULE3]
    else $error("Slot 1 enabled before the delay elapsed");

  // Delay is always within one second to one minute.
  property p_delay_range;
    @(posedge clock) disable iff (reset)
    delay_eff >= DELAY_MIN && delay_eff <= DELAY_MAX;
  endproperty
  a_delay_range: assert property (p_delay_range) // see [RULE2]
    else $error("Effective delay out of range");

  // Power-good loss clears both enables within a cycle.
  property p_pg_loss;
    @(posedge clock) disable iff (reset)
    !pg_ff |=> (en_ff == 2'b00 && state_ff == ST_IDLE);
  endproperty
  a_pg_loss: assert property (p_pg_loss) // see [RULE14]
    else $error("Enables held after power-good loss");

  // In the run state a seated slot 1 is enabled on the next cycle, unless
  // slot 0 is rising in that same cycle.
  property p_reseat;
    @(posedge clock) disable iff (reset)
    (state_ff == ST_RUN && pg_ff && present[1] &&
      (en_ff[0] || !present[0])) |=> en_ff[1];
  endproperty
  a_reseat: assert property (p_reseat) // see [RULE4]
    else $error("Re-seated board not re-enabled at once");

  // A lone slot 0 at evaluation is powered two cycles later.
  property p_lone_zero;
    @(posedge clock) disable iff (reset)
    (state_ff == ST_EVAL && pg_ff && present == 2'b01) ##1
      (pg_ff && present[0]) |=> en_ff[0];
  endproperty
  a_lone_zero: assert property (p_lone_zero) // see [RULE5]
    else $error("Lone slot 0 not enabled at once");

  // A lone slot 1 at evaluation is powered two cycles later.
  property p_lone_one;
    @(posedge clock) disable iff (reset)
    (state_ff == ST_EVAL && pg_ff && present == 2'b10) ##1
      (pg_ff && present[1]) |=> en_ff[1];
  endproperty
  a_lone_one: assert property (p_lone_one) // see [RULE6]
    else $error("Lone slot 1 not enabled at once");

  // The slot 0 fan is off whenever slot 0 power is off.
  property p_fans;
    @(posedge clock) disable iff (reset)
    !en_ff[0] |-> !slot_fan_en[0];
  endproperty
  a_fans: assert property (p_fans) // see [RULE12]
    else $error("Fans on for an unpowered slot");

  // Seconds counter only steps to a non-zero value on a second tick; clearing needs none.
  property p_sec_step;
    @(posedge clock) disable iff (reset)
    (sec_ff != $past(sec_ff) && sec_ff != '0) |-> $past(sec_tick);
  endproperty
  a_sec_step: assert property (p_sec_step) // see [RULE13]
    else $error("Seconds counter moved without a tick");

endmodule // dual_board_powerup_stagger

/* File: design/stagger_pkg.sv */
// Purpose: Shared constants for the two-slot power-up stagger sequencer.
// Assumes: A 10 MHz free-running midplane clock.
// Notes: Times are kept in their own units; cycle counts derive from them.
package stagger_pkg;
  // Clock rate in Hz.
  localparam int unsigned CLOCK_HZ = 10000000;
  // Cycles in one second of the timer tick.
  localparam int unsigned CYCLES_PER_SEC = CLOCK_HZ;
  // Stagger interval limits and reset value, in seconds.
  localparam int unsigned DELAY_MIN_SEC = 1;
  localparam int unsigned DELAY_MAX_SEC = 60;
  localparam int unsigned DELAY_DEFAULT_SEC = 30;
  // Width of the seconds counter and delay setting.
  localparam int unsigned SEC_W = 6;
  localparam logic [SEC_W-1:0] DELAY_MIN = 6'h01;
  localparam logic [SEC_W-1:0] DELAY_MAX = 6'h3c;
  localparam logic [SEC_W-1:0] DELAY_RESET = 6'h1e;
  // Number of board slots.
  localparam int unsigned SLOTS = 2;
  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVAL = 2'b01,
    ST_WAIT = 2'b11,
    ST_RUN = 2'b10
  } seq_state_t;
endpackage

/* File: sim/board_supply_model.sv */
// Purpose: Behavioural model of the supply and the two boards.
// Assumes: The bench commands power-good and slot occupancy.
// Notes: A seated board asks for power-on once its slot is powered.
`timescale 1ns/1ps
module board_supply_model
  import stagger_pkg::*;
(
  // Commands from the bench.
  input wire logic pg_cmd,
  input wire logic [SLOTS-1:0] seat_cmd,
  // Enables from the sequencer.
  input wire logic [SLOTS-1:0] slot_power_en,
  // Pins toward the sequencer.
  output logic supply_power_good,
  output logic [SLOTS-1:0] board_seated_n,
  output logic [SLOTS-1:0] board_power_request
);
  // The supply reports good power only while it is commanded on.
  assign supply_power_good = pg_cmd;
  // An empty slot reads high; a mated board pulls its line low.
  assign board_seated_n = ~seat_cmd;
  // A seated board starts its power-on once its slot is fed.
  assign board_power_request = slot_power_en & seat_cmd;
endmodule // board_supply_model

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the power-up stagger sequencer.
// Assumes: One second is shortened to ten clock cycles.
// Notes: Stagger lags are measured from the slot 0 enable.
`timescale 1ns/1ps
module testbench;
  import stagger_pkg::*;
  localparam int unsigned TICK = 10;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic pg_cmd = 1'b0;
  logic [SLOTS-1:0] seat_cmd = 2'h0;
  logic [SEC_W-1:0] delay_sec = 6'h1e;
  logic pg;
  logic [SLOTS-1:0] seated_n, req, pwr, fan, run;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  // Half period of 50 ns gives the 10 MHz clock.
  always #50 clock = ~clock;

  dual_board_powerup_stagger #(.TICK_CYCLES(TICK)) dut_u (
    .clock(clock), .reset(reset), .supply_power_good(pg),
    .board_seated_n(seated_n), .board_power_request(req),
    .delay_sec(delay_sec), .slot_power_en(pwr), .slot_fan_en(fan),
    .board_running(run));

  board_supply_model far_u (.pg_cmd(pg_cmd), .seat_cmd(seat_cmd),
    .slot_power_en(pwr), .supply_power_good(pg),
    .board_seated_n(seated_n), .board_power_request(req));

  // A hung run is cut short and counted as a mismatch.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apply(input logic p, input logic [1:0] s);
    @(negedge clock);
    pg_cmd = p;
    seat_cmd = s;
  endtask

  // Waits for one slot enable under a bounded count of cycles.
  task automatic wait_on(input int b, input int lim, output int n);
    n = 0;
    while (pwr[b] !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic power_off();
    apply(1'b0, 2'h3);
    repeat (8) @(negedge clock);
    check(pwr, 2'h0);
    check(fan, 2'h0);
    check(run, 2'h0);
  endtask

  // Both boards present at power arrival; d is the raw setting.
  task automatic both_at_power(input logic [5:0] d);
    int n, de;
    de = (d == 6'h00) ? 1 : (d > 6'h3c) ? 60 : int'(d);
    power_off();
    delay_sec = d;
    apply(1'b1, 2'h3);
    wait_on(0, 20, n);
    check(pwr, 2'h1);
    check(fan, 2'h1);
    wait_on(1, de * TICK + 20, n);
    check(n >= de * TICK, 1);
    check(n <= de * TICK + 5, 1);
    check(pwr, 2'h3);
  endtask

  // Pull and re-seat boards while both run, slot 1 alone and then both at once.
  task automatic reseat();
    int n;
    apply(1'b1, 2'h1);
    repeat (6) @(negedge clock);
    check(pwr, 2'h1);
    check(fan, 2'h1);
    check(run, 2'h1);
    apply(1'b1, 2'h3);
    repeat (8) @(negedge clock);
    check(pwr, 2'h3);
    check(run, 2'h3);
    apply(1'b1, 2'h0);
    repeat (6) @(negedge clock);
    check(pwr, 2'h0);
    apply(1'b1, 2'h3);
    wait_on(0, 20, n);
    check(pwr, 2'h1);
    repeat (2) @(negedge clock);
    check(pwr, 2'h3);
  endtask

  // A lone board at power arrival, then a newcomer in the other slot.
  task automatic lone(input logic [1:0] s);
    power_off();
    delay_sec = 6'h3c;
    apply(1'b1, s);
    repeat (10) @(negedge clock);
    check(pwr, s);
    apply(1'b1, 2'h3);
    repeat (8) @(negedge clock);
    check(pwr, 2'h3);
  endtask

  task automatic empty_then_insert();
    int n;
    power_off();
    delay_sec = 6'h02;
    apply(1'b1, 2'h0);
    repeat (8) @(negedge clock);
    check(pwr, 2'h0);
    apply(1'b1, 2'h3);
    wait_on(0, 20, n);
    check(pwr, 2'h1);
    wait_on(1, 40, n);
    check(n >= 2 * TICK, 1);
    check(n <= 2 * TICK + 5, 1);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    both_at_power(6'h1e);
    reseat();
    both_at_power(6'h00);
    both_at_power(6'h3f);
    lone(2'h1);
    lone(2'h2);
    empty_then_insert();
    power_off();
    tally_and_finish();
  end
endmodule // testbench
